// *** rtl/emw_defines.svh ***
// Purpose: Offsets, field positions, reset values and limits of the wait-state controller
// Assumes: 32-bit register port, byte offsets
// Notes:   Included by the controller and the bench
`ifndef EMW_DEFINES_SVH
`define EMW_DEFINES_SVH

`define EMW_OFS_CONTROL     8'h00
`define EMW_OFS_WAIT_MIN    8'h04
`define EMW_OFS_STATUS      8'h08
`define EMW_OFS_MAP_SELECT  8'h0C

`define EMW_CTL_ENABLE      0
`define EMW_CTL_FAST        1
`define EMW_CTL_LOCK_I      2
`define EMW_CTL_LOCK_D      3
`define EMW_CTL_PRIM_D      4
`define EMW_CTL_CLK_LO      8
`define EMW_CTL_CLK_HI      9

`define EMW_WM_BURST_LO     0
`define EMW_WM_BURST_HI     2
`define EMW_WM_SIMPLE_LO    4
`define EMW_WM_SIMPLE_HI    7

`define EMW_RST_CONTROL     10'h101
`define EMW_RST_BURST_MIN   3'h1
`define EMW_RST_SIMPLE_MIN  4'h2

`define EMW_MEM_CLK_MIN     2'h1
`define EMW_MEM_CLK_MAX     2'h2
`define EMW_BURST_MIN_LO    3'h1
`define EMW_BURST_MIN_HI    3'h4
`define EMW_SIMPLE_MIN_LO   4'h2
`define EMW_SIMPLE_MIN_HI   4'h9

`define EMW_SLOW_KHZ        16670
`define EMW_FAST_KHZ        20000
`define EMW_VFAST_KHZ       25000

`endif

// *** rtl/emw_pkg.sv ***
// Purpose: Types shared by the wait-state controller and its bench
// Assumes: Two processor buses, index 0 instruction, index 1 data
// Notes:   Constants live in emw_defines.svh
package emw_pkg;
    typedef struct packed {
        logic first;
        logic burst;
        logic simple;
        logic overlay;
        logic tgt_ready;
        logic type_hit;
    } emw_bus_in_s;

    typedef enum logic {EMW_IDLE, EMW_WAIT} emw_state_e;

    typedef enum logic [1:0] {EMW_RATE_SLOW, EMW_RATE_FAST, EMW_RATE_VFAST, EMW_RATE_OVER} emw_rate_e;
endpackage

// *** rtl/emw_ctrl.sv ***
// Purpose: Wait-state and mapper timing control between two processor buses,
//          overlay memory and target memory
// Assumes: One processor clock, synchronous inputs, synchronous active-high reset
// Notes:   Bus 0 is the instruction bus, bus 1 the data bus
`timescale 1ns/1ps
`include "emw_defines.svh"
`default_nettype none

// Summary of operation
// - Normal speed adds no translation wait
// - Fast speed adds one translation wait
// - Mapper off makes speed setting irrelevant
// - Mapper off routes to target, no waits
// - Mapper off raises no memory-type breaks
// - Mapper off passes pipeline permit through
// - Fast mapper: dead cycle per new request
// - Dead cycle on first access only
// - Fast mapper blocks target pipeline permit
// - Translate with most recently loaded map
// - Overlay clocks per access: 1 or 2
// - Burst minimum waits configurable 1 to 4
// - Simple minimum waits configurable 2 to 9
// - Collision loser takes one extra cycle
// - Natural waits padded up to minimum
// - First overlay access adds resync cycle
// - Overlay accesses always take at least one wait
// - Fast target burst gets one wait
// - Analyzer rate is clock over 1+waits
// - Rate class selects allowed counting
// - Overlay waits are larger of natural count and the type's minimum
// - Locked overlay waits for later target ready
module emw_ctrl
    import emw_pkg::*;
#(
    parameter int PROC_KHZ = 25000
) (
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire logic [7:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [31:0]       reg_rdata,
    input  wire emw_bus_in_s [1:0] bus_in,
    output logic      [1:0]        bus_ready,
    output logic      [1:0]        bus_to_target,
    output logic      [1:0]        mem_type_break,
    input  wire logic              target_pipe,
    output logic                   pipeline_permit,
    output logic      [7:0]        active_map,
    output emw_rate_e              rate_class,
    output logic                   count_state_ok,
    output logic                   count_time_ok
);

    logic [9:0]  ctl;
    logic [2:0]  burst_min;
    logic [3:0]  simple_min;
    logic [7:0]  map_sel;
    logic [9:0]  act_ctl;
    logic [2:0]  act_burst;
    logic [3:0]  act_simple;
    logic [3:0]  last_ws;
    logic [31:0] next_rdata;
    logic [1:0]  busy;
    logic [1:0]  start;

    wire wr_ctl = reg_wr && (reg_addr == `EMW_OFS_CONTROL);
    wire wr_wm  = reg_wr && (reg_addr == `EMW_OFS_WAIT_MIN);
    wire wr_map = reg_wr && (reg_addr == `EMW_OFS_MAP_SELECT);

    wire [1:0] wr_clk    = reg_wdata[`EMW_CTL_CLK_HI:`EMW_CTL_CLK_LO];
    wire [2:0] wr_burst  = reg_wdata[`EMW_WM_BURST_HI:`EMW_WM_BURST_LO];
    wire [3:0] wr_simple = reg_wdata[`EMW_WM_SIMPLE_HI:`EMW_WM_SIMPLE_LO];
    wire clk_ok    = (wr_clk >= `EMW_MEM_CLK_MIN) && (wr_clk <= `EMW_MEM_CLK_MAX);
    wire burst_ok  = (wr_burst >= `EMW_BURST_MIN_LO) && (wr_burst <= `EMW_BURST_MIN_HI);
    wire simple_ok = (wr_simple >= `EMW_SIMPLE_MIN_LO) && (wr_simple <= `EMW_SIMPLE_MIN_HI);

    // Out-of-range values are dropped so the live setting is always legal
    wire [1:0] ctl_clk_kept = clk_ok ? wr_clk : ctl[`EMW_CTL_CLK_HI:`EMW_CTL_CLK_LO];

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctl        <= `EMW_RST_CONTROL;
            burst_min  <= `EMW_RST_BURST_MIN;
            simple_min <= `EMW_RST_SIMPLE_MIN;
            map_sel    <= 8'h00;
        end else begin
            if (wr_ctl)
                ctl <= {ctl_clk_kept, 3'h0, reg_wdata[`EMW_CTL_PRIM_D:0]};
            if (wr_wm && burst_ok)
                burst_min <= wr_burst;
            if (wr_wm && simple_ok)
                simple_min <= wr_simple;
            if (wr_map)
                map_sel <= reg_wdata[7:0];
        end
    end

    // Copy live settings only while no access is in flight or starting
    wire cfg_idle = (busy == 2'b00) && (start == 2'b00);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            act_ctl    <= `EMW_RST_CONTROL;
            act_burst  <= `EMW_RST_BURST_MIN;
            act_simple <= `EMW_RST_SIMPLE_MIN;
            active_map <= 8'h00;
        end else if (cfg_idle) begin
            act_ctl    <= ctl;
            act_burst  <= burst_min;
            act_simple <= simple_min;
            active_map <= map_sel;
        end
    end

    wire       enable  = act_ctl[`EMW_CTL_ENABLE];
    wire       fast    = act_ctl[`EMW_CTL_FAST];
    wire       prim_d  = act_ctl[`EMW_CTL_PRIM_D];
    wire [3:0] mem_clk = {2'h0, act_ctl[`EMW_CTL_CLK_HI:`EMW_CTL_CLK_LO]};
    wire [1:0] lock    = act_ctl[`EMW_CTL_LOCK_D:`EMW_CTL_LOCK_I];

    // Speed setting only matters with the mapper on
    wire xlate_on = enable && fast;

    // Pipelining cannot coexist with the per-access translation cycle
    assign pipeline_permit = target_pipe && !xlate_on;

    wire [1:0] ovl_start;
    wire       collide = ovl_start[0] && ovl_start[1];
    logic [1:0] ws_done;
    logic [3:0] ws_calc [2];

    genvar b;
    generate
        for (b = 0; b < 2; b++) begin : g_bus
            emw_state_e state;
            logic [3:0] cnt;
            logic       need_tgt;

            wire req  = bus_in[b].first || bus_in[b].burst;
            wire ovl  = enable && bus_in[b].overlay;
            wire lost = collide && (prim_d ? (b == 0) : (b == 1));
            wire xl   = xlate_on && bus_in[b].first;
            wire [3:0] cyc = {3'h0, xl} + mem_clk + {3'h0, lost} + {3'h0, bus_in[b].first};
            wire [3:0] natural = cyc - 4'h1;
            wire [3:0] cfg_min = bus_in[b].simple ? act_simple : {1'b0, act_burst};
            // Overlay always has at least one wait
            wire [3:0] ovl_ws = (natural > cfg_min) ? natural : cfg_min;
            wire [3:0] tgt_ws = (xl || (xlate_on && bus_in[b].burst)) ? 4'h1 : 4'h0;
            wire [3:0] ws     = ovl ? ovl_ws : tgt_ws;
            wire       n_tgt  = !ovl || lock[b];

            assign start[b]     = enable && (state == EMW_IDLE) && req;
            assign ovl_start[b] = start[b] && ovl;
            assign busy[b]      = (state == EMW_WAIT);
            assign ws_calc[b]   = ws;

            wire idle_done = start[b] && (ws == 4'h0) && bus_in[b].tgt_ready;
            // Ready from target is only heard once the local count has run out
            wire wait_done = busy[b] && (cnt == 4'h0) && (!need_tgt || bus_in[b].tgt_ready);

            assign bus_ready[b] = enable ? (idle_done || wait_done) : bus_in[b].tgt_ready;
            assign bus_to_target[b] = !ovl;
            assign mem_type_break[b] = enable && req && bus_in[b].type_hit;
            assign ws_done[b] = bus_ready[b] && bus_in[b].burst;

            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    state    <= EMW_IDLE;
                    cnt      <= 4'h0;
                    need_tgt <= 1'b0;
                end else begin
                    case (state)
                        EMW_IDLE: begin
                            if (start[b] && !idle_done) begin
                                state    <= EMW_WAIT;
                                cnt      <= (ws == 4'h0) ? 4'h0 : ws - 4'h1;
                                need_tgt <= n_tgt;
                            end
                        end
                        EMW_WAIT: begin
                            if (cnt != 4'h0)
                                cnt <= cnt - 4'h1;
                            else if (wait_done)
                                state <= EMW_IDLE;
                        end
                        default: state <= EMW_IDLE;
                    endcase
                end
            end

            property p_no_early_ready;
                @(posedge sys_clk) disable iff (rst)
                (busy[b] && cnt != 4'h0) |-> !bus_ready[b];
            endproperty
            a_no_early_ready: assert property (p_no_early_ready) else $error("ready before waits elapsed");

            property p_overlay_waits;
                @(posedge sys_clk) disable iff (rst)
                ovl_start[b] |-> !bus_ready[b] ##1 busy[b];
            endproperty
            a_overlay_waits: assert property (p_overlay_waits) else $error("overlay access with no wait");

            // Count ran out with no target wait owed: ready must come now
            property p_wait_end;
                @(posedge sys_clk) disable iff (rst)
                (busy[b] && cnt == 4'h0 && !need_tgt) |-> bus_ready[b];
            endproperty
            a_wait_end: assert property (p_wait_end) else $error("waits elapsed but no ready");

            property p_lock_hold;
                @(posedge sys_clk) disable iff (rst)
                (busy[b] && need_tgt && !bus_in[b].tgt_ready) |-> !bus_ready[b];
            endproperty
            a_lock_hold: assert property (p_lock_hold) else $error("ready without target ready");

            sequence s_quiet_two;
                !bus_ready[b] ##1 !bus_ready[b];
            endsequence

            // Simple mode floor is two waits, so the first two cycles stay quiet
            property p_simple_floor;
                @(posedge sys_clk) disable iff (rst)
                (ovl_start[b] && bus_in[b].simple) |-> s_quiet_two;
            endproperty
            a_simple_floor: assert property (p_simple_floor) else $error("simple access under two waits");

            // Two clocks plus resync give a first access at least two waits
            property p_first_slow;
                @(posedge sys_clk) disable iff (rst)
                (ovl_start[b] && bus_in[b].first && mem_clk == 4'h2) |-> s_quiet_two;
            endproperty
            a_first_slow: assert property (p_first_slow) else $error("first access too short");

            property p_normal_zero;
                @(posedge sys_clk) disable iff (rst)
                (start[b] && !xlate_on && !ovl && bus_in[b].tgt_ready) |-> bus_ready[b];
            endproperty
            a_normal_zero: assert property (p_normal_zero) else $error("normal target access delayed");

            property p_fast_target;
                @(posedge sys_clk) disable iff (rst)
                (start[b] && xlate_on && !ovl) |-> !bus_ready[b];
            endproperty
            a_fast_target: assert property (p_fast_target) else $error("fast target access without wait");
        end
    endgenerate

    // Rate class from the most recent burst transfer's waits
    always_ff @(posedge sys_clk) begin
        if (rst)
            last_ws <= 4'h0;
        else if (ws_done[1])
            last_ws <= ws_calc[1];
        else if (ws_done[0])
            last_ws <= ws_calc[0];
    end

    wire [31:0] div = {28'h0, last_ws} + 32'h1;
    wire [31:0] pk  = PROC_KHZ;
    assign rate_class = (pk <= `EMW_SLOW_KHZ * div) ? EMW_RATE_SLOW :
                        (pk <= `EMW_FAST_KHZ * div) ? EMW_RATE_FAST :
                        (pk <= `EMW_VFAST_KHZ * div) ? EMW_RATE_VFAST : EMW_RATE_OVER;
    assign count_time_ok  = (rate_class == EMW_RATE_SLOW);
    assign count_state_ok = (rate_class == EMW_RATE_SLOW) || (rate_class == EMW_RATE_FAST);

    wire [31:0] rd_ctl    = {22'h0, ctl};
    wire [31:0] rd_wm     = {24'h0, simple_min, 1'b0, burst_min};
    wire [31:0] rd_status = {16'h0, active_map, busy, rate_class, last_ws};
    wire [31:0] rd_map    = {24'h0, map_sel};

    always_comb begin
        next_rdata = 32'h0;
        if (reg_rd) begin
            case (reg_addr)
                `EMW_OFS_CONTROL:    next_rdata = rd_ctl;
                `EMW_OFS_WAIT_MIN:   next_rdata = rd_wm;
                `EMW_OFS_STATUS:     next_rdata = rd_status;
                `EMW_OFS_MAP_SELECT: next_rdata = rd_map;
                default:             next_rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst)
            reg_rdata <= 32'h0;
        else
            reg_rdata <= next_rdata;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_fast_first;
        enable && fast && start[0] && bus_in[0].first;
    endsequence

    property p_passthrough;
        !enable |-> (bus_ready == {bus_in[1].tgt_ready, bus_in[0].tgt_ready});
    endproperty
    a_passthrough: assert property (p_passthrough) else $error("mapper off but ready altered");

    property p_no_break_off;
        !enable |-> (mem_type_break == 2'b00);
    endproperty
    a_no_break_off: assert property (p_no_break_off) else $error("break with mapper off");

    property p_pipe_pass;
        !enable |-> (pipeline_permit == target_pipe);
    endproperty
    a_pipe_pass: assert property (p_pipe_pass) else $error("pipeline permit not passed");

    property p_pipe_block;
        (enable && fast) |-> !pipeline_permit;
    endproperty
    a_pipe_block: assert property (p_pipe_block) else $error("pipeline permit leaked");

    property p_dead_cycle;
        s_fast_first |-> !bus_ready[0] ##1 busy[0];
    endproperty
    a_dead_cycle: assert property (p_dead_cycle) else $error("no translation dead cycle");

    property p_clk_legal;
        (ctl[`EMW_CTL_CLK_HI:`EMW_CTL_CLK_LO] == `EMW_MEM_CLK_MIN) ||
        (ctl[`EMW_CTL_CLK_HI:`EMW_CTL_CLK_LO] == `EMW_MEM_CLK_MAX);
    endproperty
    a_clk_legal: assert property (p_clk_legal) else $error("illegal clocks per access");

    property p_burst_range;
        (burst_min >= `EMW_BURST_MIN_LO) && (burst_min <= `EMW_BURST_MIN_HI);
    endproperty
    a_burst_range: assert property (p_burst_range) else $error("burst minimum out of range");

    property p_simple_range;
        wr_wm && !simple_ok |=> $stable(simple_min);
    endproperty
    a_simple_range: assert property (p_simple_range) else $error("illegal simple minimum taken");

    property p_cfg_hold;
        (busy != 2'b00) |=> $stable(act_ctl);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("settings changed mid access");

    property p_set_hold;
        (busy != 2'b00) |=> ($stable(act_simple) && $stable(act_burst) && $stable(active_map));
    endproperty
    a_set_hold: assert property (p_set_hold) else $error("minimums or map changed mid access");

    property p_map_load;
        cfg_idle |=> (active_map == $past(map_sel));
    endproperty
    a_map_load: assert property (p_map_load) else $error("loaded map not taken");

    // Mapper off must leave every cycle to the target, untouched
    property p_route_off;
        !enable |-> (bus_to_target == 2'b11);
    endproperty
    a_route_off: assert property (p_route_off) else $error("access kept local with mapper off");

    property p_idle_off;
        !enable |-> (busy == 2'b00);
    endproperty
    a_idle_off: assert property (p_idle_off) else $error("own waits with mapper off");

    // Time counting is only legal where state counting also is
    property p_count_nest;
        count_time_ok |-> count_state_ok;
    endproperty
    a_count_nest: assert property (p_count_nest) else $error("time count allowed without state count");

endmodule

`default_nettype wire

// *** dv/emw_tgt_model.sv ***
// Purpose: Target memory stand-in answering both processor buses
// Assumes: Requests held until bus_ready; the bench sets the ready delay per bus
// Notes:   Outside a request tgt_ready toggles, so a stale level is never trusted
`timescale 1ns/1ps
`default_nettype none
module emw_tgt_model (
    input  wire logic            sys_clk,
    input  wire logic            rst,
    input  wire logic [1:0]      req,
    input  wire logic [1:0]      first,
    input  wire logic [1:0]      bus_ready,
    input  wire logic            fast_map,
    input  wire logic [1:0]      early,
    input  wire logic [1:0][3:0] delay,
    output logic      [1:0]      tgt_ready
);
    logic [1:0][3:0] cnt;
    logic [1:0][3:0] need;
    logic            wiggle;
    always_ff @(posedge sys_clk) begin
        wiggle <= rst ? 1'b0 : ~wiggle;
        for (int b = 0; b < 2; b++) begin
            cnt[b] <= (rst || !req[b] || bus_ready[b]) ? 4'h0 : cnt[b] + 4'h1;
        end
    end
    // Early pulse lets the bench show that premature ready is ignored
    always_comb begin
        for (int b = 0; b < 2; b++) begin
            need[b] = (fast_map && first[b] && delay[b] == 4'h0) ? 4'h1 : delay[b];
            tgt_ready[b] = req[b] ? (cnt[b] >= need[b] || (early[b] && cnt[b] == 4'h0)) : wiggle;
        end
    end
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
// Purpose: Self-checking bench for the wait-state controller
// Assumes: Target model answers both buses; settings written while idle but for one write as a request is taken
// Notes:   Expected ready cycles come from an integer model of the wait rules
`timescale 1ns/1ps
`include "emw_defines.svh"
`default_nettype none
module tb_top
    import emw_pkg::*;
;
    localparam int PK = 45000;
    logic sys_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, target_pipe = 1'b0, fast_map = 1'b0;
    logic [7:0] reg_addr = 8'h00, active_map;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic [1:0] bus_ready, bus_to_target, mem_type_break, tgt_rdy, early = 2'b00;
    logic pipeline_permit, count_state_ok, count_time_ok;
    emw_rate_e rate_class;
    emw_bus_in_s [1:0] req_q = '0, bus_in;
    int n_fail = 0, total_checks = 0;
    logic [15:0] rs = 16'h000F;
    logic m_en = 1'b1, m_fast = 1'b0, m_prim = 1'b0, pipe = 1'b0;
    logic [1:0] m_lock = 2'b00, fst = 2'b00, smp = 2'b00, ovl = 2'b00, hit = 2'b00;
    int m_clk = 1, m_bmin = 1, m_smin = 2;
    int dly [2] = '{0, 0};
    always #2.5 sys_clk = ~sys_clk;
    always_comb begin
        bus_in = req_q;
        bus_in[0].tgt_ready = tgt_rdy[0];
        bus_in[1].tgt_ready = tgt_rdy[1];
    end
    emw_ctrl #(.PROC_KHZ(PK)) dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_in(bus_in), .bus_ready(bus_ready),
        .bus_to_target(bus_to_target), .mem_type_break(mem_type_break), .target_pipe(target_pipe),
        .pipeline_permit(pipeline_permit), .active_map(active_map), .rate_class(rate_class),
        .count_state_ok(count_state_ok), .count_time_ok(count_time_ok));
    emw_tgt_model tgt (.sys_clk(sys_clk), .rst(rst), .req({req_q[1].first | req_q[1].burst,
        req_q[0].first | req_q[0].burst}), .first({req_q[1].first, req_q[0].first}), .bus_ready(bus_ready),
        .fast_map(fast_map), .early(early), .delay({dly[1][3:0], dly[0][3:0]}), .tgt_ready(tgt_rdy));
    function automatic logic [15:0] nxt();
        rs = {rs[14:0], rs[15] ^ rs[13] ^ rs[12] ^ rs[10]};
        return rs;
    endfunction
    task automatic tally_and_finish();
        if (n_fail == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic chk_cyc(input string what, input int exp, input int got);
        total_checks++;
        if (got != exp) begin
            n_fail++;
            $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        chk_reg("reg_rdata", e, reg_rdata);
    endtask
    function automatic int rate_of(input int ws);
        int k;
        k = PK / (1 + ws);
        return k <= `EMW_SLOW_KHZ ? 0 : k <= `EMW_FAST_KHZ ? 1 : k <= `EMW_VFAST_KHZ ? 2 : 3;
    endfunction
    function automatic int exp_cyc(input int b, input int lost);
        int ws;
        int mn;
        if (!m_en) return dly[b];
        ws = m_fast;
        if (ovl[b]) begin
            ws = (m_fast & fst[b]) + m_clk + lost + fst[b] - 1;
            mn = smp[b] ? m_smin : m_bmin;
            ws = ws < mn ? mn : ws;
            if (!m_lock[b]) return ws;
        end
        return ws < dly[b] ? dly[b] : ws;
    endfunction
    task automatic set_cfg(input logic [15:0] r);
        logic [31:0] c;
        logic [31:0] w;
        {m_lock, m_prim, m_fast} = r[3:0];
        m_en = r[4] | r[5];
        m_clk = r[6] + 1;
        m_bmin = r[8:7] + 1;
        m_smin = r[11:9] + 2;
        c = {22'h0, m_clk[1:0], 3'h0, m_prim, m_lock, m_fast, m_en};
        w = {24'h0, m_smin[3:0], 1'b0, m_bmin[2:0]};
        wr(`EMW_OFS_CONTROL, c);
        wr(`EMW_OFS_WAIT_MIN, w);
        wr(`EMW_OFS_MAP_SELECT, {24'h0, r[15:8]});
        rd(`EMW_OFS_CONTROL, c);
        rd(`EMW_OFS_WAIT_MIN, w);
        repeat (2) @(negedge sys_clk);
        chk_reg("active_map", r[15:8], active_map);
    endtask
    task automatic access(input logic [1:0] go);
        int ex [2];
        int seen [2];
        logic [1:0] done;
        done = ~go;
        seen = '{-1, -1};
        for (int b = 0; b < 2; b++) begin
            ex[b] = exp_cyc(b, int'(go == 2'b11 && ovl == 2'b11 && m_en && b != m_prim));
        end
        @(posedge sys_clk);
        target_pipe <= pipe;
        fast_map <= m_en & m_fast;
        early <= m_lock & ovl & {2{m_en}};
        for (int b = 0; b < 2; b++) begin
            req_q[b] <= go[b] ? emw_bus_in_s'({fst[b], ~fst[b], smp[b], ovl[b], 1'b0, hit[b]}) : '0;
        end
        for (int c = 0; c < 40 && done != 2'b11; c++) begin
            @(negedge sys_clk);
            if (c == 0) begin
                chk_reg("pipeline_permit", pipe & ~(m_en & m_fast), pipeline_permit);
                chk_reg("bus_to_target", go & (~ovl | {2{~m_en}}), bus_to_target & go);
                chk_reg("mem_type_break", go & hit & {2{m_en}}, mem_type_break & go);
            end
            for (int b = 0; b < 2; b++) begin
                if (!done[b] && bus_ready[b] === 1'b1) begin
                    seen[b] = c;
                    done[b] = 1'b1;
                end
            end
            @(posedge sys_clk);
            for (int b = 0; b < 2; b++) begin
                if (done[b]) req_q[b] <= '0;
            end
        end
        chk_reg("answered", 2'b11, done);
        if (done !== 2'b11) tally_and_finish();
        @(negedge sys_clk);
        for (int b = 0; b < 2; b++) begin
            if (go[b]) chk_cyc("ready cycle", ex[b], seen[b]);
            if (go == (2'b01 << b) && m_en && ovl[b] && !fst[b] && !m_lock[b]) begin
                chk_reg("rate_class", rate_of(ex[b]), rate_class);
                chk_reg("count_state_ok", rate_of(ex[b]) < 2, count_state_ok);
                chk_reg("count_time_ok", rate_of(ex[b]) == 0, count_time_ok);
            end
        end
    endtask
    initial begin
        logic [15:0] r;
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rd(`EMW_OFS_CONTROL, 32'h101);
        rd(`EMW_OFS_WAIT_MIN, 32'h21);
        rd(`EMW_OFS_MAP_SELECT, 32'h0);
        rd(8'h10, 32'h0);
        rd(`EMW_OFS_STATUS, rate_of(0) << 4);
        wr(`EMW_OFS_CONTROL, 32'h313);
        rd(`EMW_OFS_CONTROL, 32'h113);
        wr(`EMW_OFS_WAIT_MIN, 32'hA5);
        rd(`EMW_OFS_WAIT_MIN, 32'h21);
        wr(`EMW_OFS_WAIT_MIN, 32'h13);
        rd(`EMW_OFS_WAIT_MIN, 32'h23);
        wr(`EMW_OFS_WAIT_MIN, 32'h94);
        rd(`EMW_OFS_WAIT_MIN, 32'h94);
        set_cfg(16'h0651);
        {fst, smp, ovl} = 6'b010101;
        // Write lands at the edge the request is taken, so the old minimum applies
        fork
            access(2'b01);
            wr(`EMW_OFS_WAIT_MIN, 32'h91);
        join
        m_smin = 9;
        access(2'b01);
        for (int i = 0; i < 150; i++) begin
            if (i % 10 == 0) set_cfg(nxt());
            r = nxt();
            {hit, ovl, smp, fst} = r[7:0];
            dly[0] = r[10:8];
            dly[1] = r[13:11];
            pipe = r[14];
            access(r[15] ? 2'b11 : 2'b01 << (i % 2));
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
